// ### src/sfsf_front_end.sv
// Overview of operation
// - Works with clock idling low or high
// - Release of select enters standby
// - Standby waits for self-timed operation end
// - Output lines released while deselected
// - Input ignored while deselected
// - All command bytes arrive on input line
// - Input bits captured on rising clock edge
// - Output changes only on falling clock edge
// - Dual read drives input line as lane zero
// - Output line serves as lane one
`timescale 1ns/1ns
`default_nettype none

module sfsf_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_r [D];
	logic [W-1:0] mem_nxt [D];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data;
			wr_nxt = (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
		end
		if (pop) begin
			rd_nxt = (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_r <= '{default: '0};
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

module sfsf_front_end
	import sfsf_pkg::*;
#(
	parameter int FIFO_DEPTH = SFSF_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic dual_lane_zero_in,
	output logic dual_lane_zero_out,
	output logic dual_lane_zero_oe,
	output logic dual_lane_one_out,
	output logic dual_lane_one_oe,
	input wire logic busy,
	input wire sfsf_mode_t mode,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	output sfsf_rx_t rx,
	output logic frame_start,
	output logic frame_end,
	output logic standby
);
	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	sfsf_pins_t s1_r, s2_r, d_r;
	sfsf_pins_t pins;
	logic rise, fall, cs_fall, cs_rise;
	assign pins = '{cs_n: cs_n_pin, sck: sck_pin, si: dual_lane_zero_in};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= SFSF_PINS_RST;
			s2_r <= SFSF_PINS_RST;
			d_r <= SFSF_PINS_RST;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			d_r <= s2_r;
		end
	end
	// edges found at either idle level
	assign rise = s2_r.sck & ~d_r.sck;
	assign fall = ~s2_r.sck & d_r.sck;
	assign cs_fall = ~s2_r.cs_n & d_r.cs_n;
	assign cs_rise = s2_r.cs_n & ~d_r.cs_n;
	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	sfsf_state_t state_r, state_nxt;
	logic active;
	logic frame_start_nxt, frame_end_nxt;
	assign active = (state_r == SFSF_ST_ACTIVE);
	always_comb begin
		state_nxt = state_r;
		frame_start_nxt = 1'b0;
		frame_end_nxt = 1'b0;
		case (state_r)
			SFSF_ST_STANDBY, SFSF_ST_WAIT: begin
				if (cs_fall) begin
					state_nxt = SFSF_ST_ACTIVE;
					frame_start_nxt = 1'b1;
				end else if (state_r == SFSF_ST_WAIT && !busy) begin
					state_nxt = SFSF_ST_STANDBY;
				end
			end
			SFSF_ST_ACTIVE: begin
				if (cs_rise) begin
					frame_end_nxt = 1'b1;
					state_nxt = busy ? SFSF_ST_WAIT : SFSF_ST_STANDBY;
				end
			end
			default: begin
				state_nxt = SFSF_ST_STANDBY;
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SFSF_ST_STANDBY;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			state_r <= state_nxt;
			frame_start <= frame_start_nxt;
			frame_end <= frame_end_nxt;
		end
	end
	assign standby = (state_r == SFSF_ST_STANDBY);
	// ----------------------------------------
	// Input shifter
	// ----------------------------------------
	logic [7:0] in_sr_r, in_sr_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic first_r, first_nxt;
	logic rx_valid_nxt;
	sfsf_rx_t rx_nxt;
	always_comb begin
		in_sr_nxt = in_sr_r;
		bit_cnt_nxt = bit_cnt_r;
		first_nxt = first_r;
		rx_valid_nxt = 1'b0;
		rx_nxt = rx;
		if (frame_start_nxt) begin
			bit_cnt_nxt = SFSF_CNT_RST;
			first_nxt = 1'b1;
		end else if (active && !cs_rise && rise && !dual_lane_zero_oe) begin
			in_sr_nxt = {in_sr_r[6:0], s2_r.si};
			bit_cnt_nxt = bit_cnt_r + 1'b1;
			if (bit_cnt_r == SFSF_LAST_BIT) begin
				rx_valid_nxt = 1'b1;
				rx_nxt = '{first: first_r, data: {in_sr_r[6:0], s2_r.si}};
				first_nxt = 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_sr_r <= SFSF_BYTE_RST;
			bit_cnt_r <= SFSF_CNT_RST;
			first_r <= 1'b0;
			rx_valid <= 1'b0;
			rx <= SFSF_RX_RST;
		end else begin
			in_sr_r <= in_sr_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			first_r <= first_nxt;
			rx_valid <= rx_valid_nxt;
			rx <= rx_nxt;
		end
	end
	// ----------------------------------------
	// Output buffer and shifter
	// ----------------------------------------
	logic fifo_valid, fifo_ready;
	logic [7:0] fifo_data;
	logic [7:0] out_sr_r, out_sr_nxt, cur;
	logic [2:0] out_cnt_r, out_cnt_nxt;
	logic shift;
	logic one_nxt, one_oe_nxt, zero_nxt, zero_oe_nxt;
	sfsf_fifo #(.W(SFSF_BYTE_W), .D(FIFO_DEPTH)) u_tx_fifo (.clk(clk), .rst_n(rst_n),
		.in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
		.out_valid(fifo_valid), .out_ready(fifo_ready), .out_data(fifo_data));
	assign shift = active && !cs_rise && fall && mode.drive;
	assign fifo_ready = shift && (out_cnt_r == SFSF_CNT_RST);
	assign cur = (out_cnt_r != SFSF_CNT_RST) ? out_sr_r : (fifo_valid ? fifo_data : SFSF_FILL_BYTE);
	always_comb begin
		out_sr_nxt = out_sr_r;
		out_cnt_nxt = out_cnt_r;
		one_nxt = dual_lane_one_out;
		zero_nxt = dual_lane_zero_out;
		one_oe_nxt = dual_lane_one_oe;
		zero_oe_nxt = dual_lane_zero_oe;
		if (frame_start_nxt) begin
			out_cnt_nxt = SFSF_CNT_RST;
		end
		if (shift) begin
			one_oe_nxt = 1'b1;
			zero_oe_nxt = mode.dual;
			if (mode.dual) begin
				one_nxt = cur[7];
				zero_nxt = cur[6];
				out_sr_nxt = {cur[5:0], 2'b00};
				out_cnt_nxt = (out_cnt_r == SFSF_CNT_RST) ? SFSF_DUAL_STEPS : out_cnt_r - 1'b1;
			end else begin
				one_nxt = cur[7];
				out_sr_nxt = {cur[6:0], 1'b0};
				out_cnt_nxt = (out_cnt_r == SFSF_CNT_RST) ? SFSF_SINGLE_STEPS : out_cnt_r - 1'b1;
			end
		end else if (active && fall) begin
			one_oe_nxt = 1'b0;
			zero_oe_nxt = 1'b0;
		end
		if (state_nxt != SFSF_ST_ACTIVE) begin
			one_oe_nxt = 1'b0;
			zero_oe_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_sr_r <= SFSF_BYTE_RST;
			out_cnt_r <= SFSF_CNT_RST;
			dual_lane_one_out <= 1'b0;
			dual_lane_zero_out <= 1'b0;
			dual_lane_one_oe <= 1'b0;
			dual_lane_zero_oe <= 1'b0;
		end else begin
			out_sr_r <= out_sr_nxt;
			out_cnt_r <= out_cnt_nxt;
			dual_lane_one_out <= one_nxt;
			dual_lane_zero_out <= zero_nxt;
			dual_lane_one_oe <= one_oe_nxt;
			dual_lane_zero_oe <= zero_oe_nxt;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_hiz_deselect;
		state_r != SFSF_ST_ACTIVE |-> !dual_lane_one_oe && !dual_lane_zero_oe;
	endproperty
	a_hiz_deselect: assert property (p_hiz_deselect) else $error("output driven while deselected");
	property p_standby_release;
		active && cs_rise && !busy |=> standby && frame_end;
	endproperty
	a_standby_release: assert property (p_standby_release) else $error("no standby after release");
	property p_wait_busy;
		state_r == SFSF_ST_WAIT && busy |=> !standby;
	endproperty
	a_wait_busy: assert property (p_wait_busy) else $error("standby while still busy");
	property p_ignore_deselect;
		state_r != SFSF_ST_ACTIVE |=> !rx_valid;
	endproperty
	a_ignore_deselect: assert property (p_ignore_deselect) else $error("byte taken while deselected");
	property p_capture_rise;
		rx_valid |-> $past(rise) && $past(bit_cnt_r) == SFSF_LAST_BIT;
	endproperty
	a_capture_rise: assert property (p_capture_rise) else $error("byte not closed on rising edge");
	property p_out_fall;
		$changed(dual_lane_one_out) || $changed(dual_lane_zero_out) |-> $past(fall);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("output changed off falling edge");
	property p_dual_fill;
		shift && mode.dual && out_cnt_r == SFSF_CNT_RST && !fifo_valid
			|=> dual_lane_zero_out && dual_lane_one_out && dual_lane_zero_oe;
	endproperty
	a_dual_fill: assert property (p_dual_fill) else $error("dual lanes not driven");
	property p_lane_one;
		dual_lane_zero_oe |-> dual_lane_one_oe;
	endproperty
	a_lane_one: assert property (p_lane_one) else $error("lane one idle in dual mode");
	property p_no_input_dual;
		dual_lane_zero_oe && $past(dual_lane_zero_oe) |-> !rx_valid;
	endproperty
	a_no_input_dual: assert property (p_no_input_dual) else $error("input taken while lane zero drives");
	property p_opcode_first;
		frame_start |-> ##[1:2] first_r && bit_cnt_r == SFSF_CNT_RST;
	endproperty
	a_opcode_first: assert property (p_opcode_first) else $error("frame did not arm opcode");
	c_mode0_start: cover property (cs_fall && !s2_r.sck && state_r != SFSF_ST_ACTIVE);
	c_mode3_start: cover property (cs_fall && s2_r.sck && state_r != SFSF_ST_ACTIVE);
	c_dual_byte: cover property (fifo_ready && fifo_valid && mode.dual);
	c_busy_wait: cover property (state_r == SFSF_ST_WAIT ##1 standby);
endmodule

`default_nettype wire

// ### inc/sfsf_pkg.sv
package sfsf_pkg;

	// ----------------------------------------
	// Widths and counts
	// ----------------------------------------
	localparam int SFSF_BYTE_W = 8;
	localparam int SFSF_FIFO_DEPTH = 4;
	localparam logic [2:0] SFSF_LAST_BIT = 3'h7;
	localparam logic [2:0] SFSF_SINGLE_STEPS = 3'h7;
	localparam logic [2:0] SFSF_DUAL_STEPS = 3'h3;

	// ----------------------------------------
	// Values after reset and fill byte for an empty buffer
	// ----------------------------------------
	localparam logic [2:0] SFSF_CNT_RST = 3'h0;
	localparam logic [7:0] SFSF_BYTE_RST = 8'h00;
	localparam logic [7:0] SFSF_FILL_BYTE = 8'hff;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SFSF_ST_STANDBY,
		SFSF_ST_ACTIVE,
		SFSF_ST_WAIT
	} sfsf_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sfsf_pins_t;

	typedef struct packed {
		logic first;
		logic [7:0] data;
	} sfsf_rx_t;

	typedef struct packed {
		logic drive;
		logic dual;
	} sfsf_mode_t;

	localparam sfsf_pins_t SFSF_PINS_RST = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
	localparam sfsf_rx_t SFSF_RX_RST = '{first: 1'b0, data: 8'h00};

endpackage

// ### bench/sfsf_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------
// Host model
// ------------
module sfsf_host (
	input wire logic clk,
	input wire logic so_w,
	input wire logic si_w,
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic begin_frame(input logic m3);
		@(negedge clk) sck = m3;
		repeat (4) @(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic end_frame(input logic m3);
		@(negedge clk) sck = m3;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	task automatic xfer(input logic [7:0] b, input logic dual, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < (dual ? 4 : 8); i++) begin
			@(negedge clk) sck = 1'b0;
			si = dual ? ~si : b[7-i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (4) @(negedge clk);
			q = dual ? {q[5:0], so_w, si_w} : {q[6:0], so_w};
		end
	endtask
	// Activity while deselected
	task automatic noise();
		repeat (8) begin
			@(negedge clk) sck = ~sck;
			si = ~si;
			repeat (4) @(negedge clk);
		end
		sck = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### bench/serial_flash_spi_front_end_test.sv
`timescale 1ns/1ns
`default_nettype none
// ------------
// Testbench
// ------------
module serial_flash_spi_front_end_test;
	import sfsf_pkg::*;
	logic clk, rst_n, busy, tx_valid;
	logic [7:0] tx_data, q;
	sfsf_mode_t mode;
	wire logic cs_n, sck, si_h, z_out, z_oe, o_out, o_oe, tx_ready, rx_valid;
	wire logic frame_start, frame_end, standby;
	sfsf_rx_t rx;
	wire logic so_w = o_oe ? o_out : 1'bz;
	wire logic si_w = z_oe ? z_out : si_h;
	int fails = 0, total_checks = 0, starts = 0, ends = 0, cyc = 0, n;
	logic [8:0] rxq[$];

	sfsf_front_end u_dut (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n), .sck_pin(sck),
		.dual_lane_zero_in(si_w), .dual_lane_zero_out(z_out), .dual_lane_zero_oe(z_oe),
		.dual_lane_one_out(o_out), .dual_lane_one_oe(o_oe), .busy(busy), .mode(mode),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
		.rx(rx), .frame_start(frame_start), .frame_end(frame_end), .standby(standby));
	sfsf_host u_host (.clk(clk), .so_w(so_w), .si_w(si_w), .cs_n(cs_n), .sck(sck), .si(si_h));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (rx_valid === 1'b1) rxq.push_back(rx);
		if (frame_start === 1'b1) starts++;
		if (frame_end === 1'b1) ends++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_reset();
		chk(standby, 1'b1);
		chk({o_oe, z_oe}, 2'h0);
		chk(tx_ready, 1'b1);
	endtask
	task automatic t_write();
		rxq.delete();
		u_host.begin_frame(1'b0);
		u_host.xfer(8'h9c, 1'b0, q);
		u_host.xfer(8'h35, 1'b0, q);
		u_host.end_frame(1'b0);
		chk(rxq.size(), 2);
		chk(rxq[0], {1'b1, 8'h9c});
		chk(rxq[1], {1'b0, 8'h35});
		chk({starts[3:0], ends[3:0]}, 8'h11);
		chk(standby, 1'b1);
	endtask
	task automatic t_idle();
		rxq.delete();
		u_host.noise();
		chk(rxq.size(), 0);
		chk({o_oe, z_oe, standby}, 3'h1);
	endtask
	task automatic t_read(input logic m3, input logic d);
		n = 0;
		@(negedge clk) tx_valid = 1'b1;
		repeat (6) begin
			tx_data = 8'ha0 + n[7:0];
			if (tx_ready === 1'b1) n++;
			@(negedge clk);
		end
		tx_valid = 1'b0;
		chk(n, 4);
		u_host.begin_frame(m3);
		u_host.xfer(8'h3b, 1'b0, q);
		mode = '{drive: 1'b1, dual: d};
		for (int i = 0; i < 5; i++) begin
			u_host.xfer(8'h00, d, q);
			chk(q, (i == 4) ? 8'hff : 8'ha0 + i[7:0]);
		end
		chk({o_oe, z_oe}, {1'b1, d});
		mode = '{drive: 1'b0, dual: 1'b0};
		u_host.end_frame(m3);
		chk({o_oe, z_oe}, 2'h0);
	endtask
	task automatic t_busy();
		busy = 1'b1;
		u_host.begin_frame(1'b0);
		u_host.xfer(8'h20, 1'b0, q);
		u_host.end_frame(1'b0);
		chk(standby, 1'b0);
		busy = 1'b0;
		repeat (3) @(negedge clk);
		chk(standby, 1'b1);
	endtask

	initial begin
		rst_n = 1'b0;
		busy = 1'b0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		mode = '{drive: 1'b0, dual: 1'b0};
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_write();
		t_idle();
		t_read(1'b1, 1'b0);
		t_read(1'b0, 1'b1);
		t_busy();
		tally_and_finish();
	end
endmodule
`default_nettype wire
